/* File: src/cpm_monitor.v */
// Local design decisions: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`include "cpm_defs.vh"

module cpm_monitor #(
  parameter [31:0] CYC_PER_MS = `CPM_CYC_PER_MS
) (
  input  wire        clk,
  input  wire        resetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output wire [31:0] hrdata,
  input  wire        closed_contact_input,
  input  wire        open_contact_input,
  output wire        pair_ok_output,
  output wire        ready,
  output wire        error,
  output wire [15:0] diagnostic_code
);

  ////////////////////////////////////////////////////////////////////////////
  // States

  localparam [2:0] ST_IDLE     = 3'h0;
  localparam [2:0] ST_INIT     = 3'h1;
  localparam [2:0] ST_ENABLED  = 3'h2;
  localparam [2:0] ST_WAIT_NO  = 3'h3;
  localparam [2:0] ST_WAIT_NC  = 3'h4;
  localparam [2:0] ST_FROM_ACT = 3'h5;
  localparam [2:0] ST_ERR1     = 3'h6;
  localparam [2:0] ST_ERR2     = 3'h7;

  // Third error has no spare code in three bits, so it is a separate flag state
  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg         err3_q;
  reg         err3_d;

  ////////////////////////////////////////////////////////////////////////////
  // Bus side registers

  reg         activate_q;
  reg  [15:0] mismatch_q;
  reg  [31:0] hrdata_q;
  reg         hreadyout_q;
  reg         hresp_q;
  reg         wr_pend_q;
  reg  [3:0]  wr_addr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Monitor registers

  reg         nc_q;
  reg         no_q;
  reg  [31:0] cnt_q;
  reg  [31:0] cnt_d;
  reg         out_q;
  reg         ready_q;
  reg         error_q;
  reg  [15:0] code_q;

  wire        addr_ok;
  wire        timeout;
  wire [31:0] limit;

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  function is_wait;
    input [2:0] st;
    input       e3;
    begin
      is_wait = !e3 && ((st == ST_WAIT_NO) || (st == ST_WAIT_NC) || (st == ST_FROM_ACT));
    end
  endfunction

  function [15:0] code_of;
    input [2:0] st;
    input       e3;
    begin
      if (e3) begin
        code_of = `CPM_CODE_ERR3;
      end else begin
        case (st)
          ST_IDLE:     code_of = `CPM_CODE_IDLE;
          ST_INIT:     code_of = `CPM_CODE_INIT;
          ST_ENABLED:  code_of = `CPM_CODE_ENABLED;
          ST_WAIT_NO:  code_of = `CPM_CODE_WAIT_NO;
          ST_WAIT_NC:  code_of = `CPM_CODE_WAIT_NC;
          ST_FROM_ACT: code_of = `CPM_CODE_FROM_ACT;
          ST_ERR1:     code_of = `CPM_CODE_ERR1;
          ST_ERR2:     code_of = `CPM_CODE_ERR2;
          default:     code_of = `CPM_CODE_IDLE;
        endcase
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states, always OKAY

  assign addr_ok = hsel && htrans[1] && hready;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_pend_q   <= 1'b0;
      wr_addr_q   <= 4'h0;
      hrdata_q    <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
      // High addresses must not alias onto the mapped words
      wr_pend_q   <= addr_ok && hwrite && (haddr[31:4] == 28'h0000000);
      wr_addr_q   <= haddr[3:0];
      hrdata_q    <= 32'h0000_0000;
      // Read data is captured at the address phase so it stands in the data phase
      if (addr_ok && !hwrite && (haddr[31:4] == 28'h0000000)) begin
        case (haddr[3:0])
          `CPM_ADDR_CTRL: begin
            hrdata_q[`CPM_CTRL_ACTIVATE] <= activate_q;
          end
          `CPM_ADDR_MISMATCH: begin
            hrdata_q[15:0] <= mismatch_q;
          end
          `CPM_ADDR_STATUS: begin
            hrdata_q[15:0]            <= code_q;
            hrdata_q[`CPM_STAT_READY] <= ready_q;
            hrdata_q[`CPM_STAT_ERROR] <= error_q;
            hrdata_q[`CPM_STAT_OUT]   <= out_q;
            hrdata_q[`CPM_STAT_NC]    <= nc_q;
            hrdata_q[`CPM_STAT_NO]    <= no_q;
          end
          default: begin
            hrdata_q <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // Writes land in the data phase; unmapped and high addresses are ignored
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      activate_q <= `CPM_RST_ACTIVATE;
      mismatch_q <= `CPM_RST_MISMATCH;
    end else if (wr_pend_q) begin
      case (wr_addr_q)
        `CPM_ADDR_CTRL: begin
          activate_q <= hwdata[`CPM_CTRL_ACTIVATE];
        end
        // RULE13: configurable mismatch time
        `CPM_ADDR_MISMATCH: begin
          mismatch_q <= hwdata[15:0];
        end
        default: begin
          activate_q <= activate_q;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input sampling

  // RULE16: reset levels of the channels
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      nc_q <= `CPM_RST_NC;
      no_q <= `CPM_RST_NO;
    end else begin
      nc_q <= closed_contact_input;
      no_q <= open_contact_input;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mismatch timer

  // RULE20: limit in clock ticks, strictly exceeded
  assign limit   = mismatch_q * CYC_PER_MS[15:0];
  assign timeout = cnt_q > limit;

  // RULE4: timer restarts on every entry to a wait state
  always @* begin
    cnt_d = 32'h0000_0000;
    if (is_wait(state_q, err3_q) && (state_d == state_q) && !err3_d) begin
      cnt_d = (cnt_q == 32'hffff_ffff) ? cnt_q : cnt_q + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pair state machine; channel pair is judged as one value

  always @* begin
    state_d = state_q;
    err3_d  = err3_q;
    // RULE12: activate low wins over everything
    if (!activate_q) begin
      state_d = ST_IDLE;
      err3_d  = 1'b0;
    end else if (err3_q) begin
      // RULE8: error clears only with both inactive
      if (!nc_q && no_q) begin
        state_d = ST_INIT;
        err3_d  = 1'b0;
      end
    end else begin
      // RULE3: joint evaluation of both channels
      case (state_q)
        ST_IDLE: begin
          state_d = ST_INIT;
        end
        ST_INIT: begin
          // RULE18: order of arrival picks the wait state
          if (nc_q && !no_q) begin
            state_d = ST_ENABLED;
          end else if (nc_q && no_q) begin
            state_d = ST_WAIT_NO;
          end else if (!nc_q && !no_q) begin
            state_d = ST_WAIT_NC;
          end
        end
        ST_WAIT_NO: begin
          // RULE1: enabled only if pair completes in time
          if (nc_q && !no_q) begin
            state_d = ST_ENABLED;
          end else if (!nc_q && no_q) begin
            state_d = ST_INIT;
          // RULE9: late open contact
          end else if (timeout) begin
            state_d = ST_ERR1;
          end
        end
        ST_WAIT_NC: begin
          if (nc_q && !no_q) begin
            state_d = ST_ENABLED;
          end else if (!nc_q && no_q) begin
            state_d = ST_INIT;
          // RULE10: late closed contact
          end else if (timeout) begin
            state_d = ST_ERR2;
          end
        end
        ST_ENABLED: begin
          // RULE6: any change drops the output at once
          if (!nc_q && no_q) begin
            state_d = ST_INIT;
          end else if (!(nc_q && !no_q)) begin
            // RULE19: wait for the second channel
            state_d = ST_FROM_ACT;
          end
        end
        ST_FROM_ACT: begin
          if (!nc_q && no_q) begin
            state_d = ST_INIT;
          // RULE11: late return to inactive
          end else if (timeout) begin
            err3_d = 1'b1;
          end
        end
        ST_ERR1, ST_ERR2: begin
          // RULE8: latched until both inactive
          if (!nc_q && no_q) begin
            state_d = ST_INIT;
          end
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  // RULE5: timeout moves into a latched error state
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      err3_q  <= 1'b0;
      cnt_q   <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      err3_q  <= err3_d;
      cnt_q   <= cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs, taken from the next state so they move with it

  // Output comes back as soon as the pair is good; downstream must interlock
  // RULE15: no restart interlock
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_q   <= 1'b0;
      ready_q <= 1'b0;
      error_q <= 1'b0;
      code_q  <= `CPM_CODE_IDLE;
    end else begin
      // RULE2: output low in every state but enabled
      out_q   <= !err3_d && (state_d == ST_ENABLED);
      // RULE17: ready low only in idle
      ready_q <= (state_d != ST_IDLE);
      // RULE7: error flag and code together
      error_q <= err3_d || (state_d == ST_ERR1) || (state_d == ST_ERR2);
      code_q  <= code_of(state_d, err3_d);
    end
  end

  assign pair_ok_output  = out_q;
  assign ready           = ready_q;
  assign error           = error_q;
  assign diagnostic_code = code_q;
  assign hrdata          = hrdata_q;
  assign hreadyout       = hreadyout_q;
  assign hresp           = hresp_q;

endmodule

/* File: src/cpm_defs.vh */
// Function
// RULE1: Output high only when both channels active and reached that within mismatch time.
// RULE2: Output low when any channel inactive or inputs changed outside the window.
// RULE3: Both channels are judged together as one pair with one result.
// RULE4: A change that breaks the complementary pattern starts the mismatch timer.
// RULE5: Timer reaching the limit before pattern returns enters an error state.
// RULE6: With output high, any channel change drops the output at once.
// RULE7: On error, output low, error flag high, specific code on diagnostic output.
// RULE8: Error holds until closed contact low and open contact high together.
// RULE9: Timeout waiting for open contact to fall gives code c001, ready high.
// RULE10: Timeout waiting for closed contact to rise gives code c002, ready high.
// RULE11: Second channel late on way back from enabled gives code c003.
// RULE12: Activate low forces idle from any state, above all other moves.
// RULE13: Mismatch time is configurable, maximum allowed duration, default zero ms.
// RULE14: Integrator sets mismatch time longer than the evaluation period.
// RULE15: No restart interlock; output re-enables itself, downstream must interlock.
// RULE16: Closed contact high means closed; after reset it reads low, open reads high.
// RULE17: Idle 0000 ready low; init 8001 ready high; enabled 8000 output high.
// RULE18: Closed rising first waits for open with 8004; reverse order reports 8014.
// RULE19: Leaving enabled on one channel starts timer, waits with 8005, output low.
// RULE20: Timer counts clock ticks; timeout when elapsed exceeds the limit.
`ifndef CPM_DEFS_VH
`define CPM_DEFS_VH

// Register byte offsets
`define CPM_ADDR_CTRL      4'h0
`define CPM_ADDR_MISMATCH  4'h4
`define CPM_ADDR_STATUS    4'h8

// Field positions
`define CPM_CTRL_ACTIVATE  0
`define CPM_STAT_READY     16
`define CPM_STAT_ERROR     17
`define CPM_STAT_OUT       18
`define CPM_STAT_NC        19
`define CPM_STAT_NO        20

// Reset values
`define CPM_RST_ACTIVATE   1'b0
`define CPM_RST_MISMATCH   16'h0000
`define CPM_RST_NC         1'b0
`define CPM_RST_NO         1'b1

// Diagnostic codes
`define CPM_CODE_IDLE      16'h0000
`define CPM_CODE_INIT      16'h8001
`define CPM_CODE_ENABLED   16'h8000
`define CPM_CODE_WAIT_NO   16'h8004
`define CPM_CODE_WAIT_NC   16'h8014
`define CPM_CODE_FROM_ACT  16'h8005
`define CPM_CODE_ERR1      16'hc001
`define CPM_CODE_ERR2      16'hc002
`define CPM_CODE_ERR3      16'hc003

// Timing: clock period in ns, one unit of mismatch time in ns
`define CPM_CLK_PERIOD_NS  100
`define CPM_MS_NS          1000000
`define CPM_CYC_PER_MS     (`CPM_MS_NS / `CPM_CLK_PERIOD_NS)

`endif

/* File: tb/cpm_switch_model.sv */
`timescale 1ns/1ns
module cpm_switch_model (
  input  wire logic       clk,
  input  wire logic       pos,
  input  wire logic       nc_first,
  input  wire logic [7:0] skew,
  output wire logic       closed_contact_input,
  output wire logic       open_contact_input
);
  logic       lead_q = 1'b0;
  logic       lag_q = 1'b0;
  logic [7:0] cnt_q = 8'h00;
  // Lagging contact follows skew+1 ticks after the leading one; ff models a welded contact
  always @(posedge clk) begin
    lead_q <= pos;
    if (lag_q == lead_q) begin
      cnt_q <= 8'h00;
    end else if (cnt_q >= skew && skew != 8'hff) begin
      lag_q <= lead_q;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  assign closed_contact_input = nc_first ? lead_q : lag_q;
  assign open_contact_input   = nc_first ? ~lag_q : ~lead_q;
endmodule

/* File: tb/cpm_assertions.sv */
`timescale 1ns/1ns
`include "cpm_defs.vh"
module cpm_checker (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        closed_contact_input,
  input wire logic        open_contact_input,
  input wire logic        pair_ok_output,
  input wire logic        ready,
  input wire logic        error,
  input wire logic [15:0] diagnostic_code
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Pins held two samples, so the state machine has seen them
  sequence s_both_hi;
    closed_contact_input && open_contact_input && $past(closed_contact_input) && $past(open_contact_input);
  endsequence
  sequence s_both_lo;
    !closed_contact_input && !open_contact_input && !$past(closed_contact_input) && !$past(open_contact_input);
  endsequence
  a_out_needs_pair: assert property (
    pair_ok_output |-> $past(closed_contact_input, 2) && !$past(open_contact_input, 2))
    else $error("output high without active pair");
  a_out_drops_fast: assert property (
    pair_ok_output && !(closed_contact_input && !open_contact_input) |=> ##1 !pair_ok_output)
    else $error("output kept high after channel change");
  a_code_tracks_out: assert property (
    pair_ok_output == (diagnostic_code == `CPM_CODE_ENABLED))
    else $error("output and enabled code disagree");
  a_error_forces_low: assert property (
    error |-> !pair_ok_output && ready && diagnostic_code[15:12] == 4'hc)
    else $error("error state outputs wrong");
  a_ready_not_idle: assert property (
    ready == (diagnostic_code != `CPM_CODE_IDLE))
    else $error("ready wrong for code");
  a_error_clears_inactive: assert property (
    $fell(error) |-> diagnostic_code == `CPM_CODE_IDLE || (diagnostic_code == `CPM_CODE_INIT
      && !$past(closed_contact_input, 2) && $past(open_contact_input, 2)))
    else $error("error left without inactive pair");
  a_error_cause: assert property (
    $rose(error) |-> (diagnostic_code == `CPM_CODE_ERR1 && $past(diagnostic_code) == `CPM_CODE_WAIT_NO)
      || (diagnostic_code == `CPM_CODE_ERR2 && $past(diagnostic_code) == `CPM_CODE_WAIT_NC)
      || (diagnostic_code == `CPM_CODE_ERR3 && $past(diagnostic_code) == `CPM_CODE_FROM_ACT))
    else $error("error code does not match wait state");
  a_wait_no_entry: assert property (
    diagnostic_code == `CPM_CODE_INIT ##0 s_both_hi |=> diagnostic_code inside {`CPM_CODE_WAIT_NO, 16'h0})
    else $error("closed first did not start wait");
  a_wait_nc_entry: assert property (
    diagnostic_code == `CPM_CODE_INIT ##0 s_both_lo |=> diagnostic_code inside {`CPM_CODE_WAIT_NC, 16'h0})
    else $error("open first did not start wait");
endmodule
bind cpm_monitor cpm_checker cpm_checker_i (.clk(clk), .resetn(resetn), .closed_contact_input(closed_contact_input),
  .open_contact_input(open_contact_input), .pair_ok_output(pair_ok_output), .ready(ready), .error(error),
  .diagnostic_code(diagnostic_code));

/* File: tb/testbench.sv */
`timescale 1ns/1ns
`include "cpm_defs.vh"
module testbench;
  logic        clk;
  logic        resetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  wire         hreadyout;
  wire         hresp;
  wire  [31:0] hrdata;
  wire         nc;
  wire         no;
  wire         pair_ok;
  wire         rdy;
  wire         err;
  wire  [15:0] code;
  logic        pos;
  logic        nc_first;
  logic [7:0]  skew;
  logic [31:0] rd;
  int          fail_count;
  int          n_compared;
  // Ten ticks per ms keeps the timeouts short
  cpm_monitor #(.CYC_PER_MS(10)) cpm_monitor_i (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .closed_contact_input(nc), .open_contact_input(no), .pair_ok_output(pair_ok),
    .ready(rdy), .error(err), .diagnostic_code(code));
  cpm_switch_model cpm_switch_model_i (.clk(clk), .pos(pos), .nc_first(nc_first), .skew(skew),
    .closed_contact_input(nc), .open_contact_input(no));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #500000;
    fail_count++;
    stop_test();
  end
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  // Flags are {output, error, ready}
  task status(input logic [15:0] c, input logic [2:0] f);
    bus(1'b0, `CPM_ADDR_STATUS, 32'h0);
    chk("status code", {16'h0, c}, {16'h0, rd[15:0]});
    chk("status flags", {29'h0, f}, {29'h0, rd[18:16]});
    chk("port code", {16'h0, c}, {16'h0, code});
    chk("port flags", {29'h0, f}, {29'h0, pair_ok, err, rdy});
  endtask
  task sw(input logic p, input logic f, input logic [7:0] s, input int n);
    pos <= p;
    nc_first <= f;
    skew <= s;
    repeat (n) @(posedge clk);
  endtask
  task t_reset;
    bus(1'b0, `CPM_ADDR_STATUS, 32'h0);
    chk("sampled pair", 32'h0010_0000, rd & 32'h0018_0000);
    status(`CPM_CODE_IDLE, 3'b000);
    bus(1'b0, `CPM_ADDR_MISMATCH, 32'h0);
    chk("mismatch reset", 32'h0, rd);
    bus(1'b1, 32'h3c, 32'hffff_ffff);
    bus(1'b0, 32'h3c, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("hresp", 32'h0, {31'h0, hresp});
    bus(1'b1, `CPM_ADDR_MISMATCH, 32'h2);
    bus(1'b1, `CPM_ADDR_CTRL, 32'h1);
    sw(1'b0, 1'b1, 8'h0, 3);
    status(`CPM_CODE_INIT, 3'b001);
  endtask
  task t_enable_drop;
    sw(1'b1, 1'b1, 8'd18, 24);
    status(`CPM_CODE_ENABLED, 3'b101);
    sw(1'b0, 1'b1, 8'd6, 3);
    status(`CPM_CODE_FROM_ACT, 3'b001);
    sw(1'b0, 1'b1, 8'd6, 12);
    status(`CPM_CODE_INIT, 3'b001);
  endtask
  task t_err(input logic f, input logic [15:0] cw, input logic [15:0] ce);
    sw(1'b1, f, 8'hff, 4);
    status(cw, 3'b001);
    sw(1'b1, f, 8'hff, 30);
    status(ce, 3'b011);
    status(ce, 3'b011);
    sw(1'b0, f, 8'hff, 6);
    status(`CPM_CODE_INIT, 3'b001);
  endtask
  task t_err3;
    sw(1'b1, 1'b1, 8'h0, 8);
    status(`CPM_CODE_ENABLED, 3'b101);
    sw(1'b0, 1'b1, 8'hff, 30);
    status(`CPM_CODE_ERR3, 3'b011);
    bus(1'b1, `CPM_ADDR_CTRL, 32'h0);
    sw(1'b0, 1'b1, 8'hff, 2);
    status(`CPM_CODE_IDLE, 3'b000);
    sw(1'b0, 1'b1, 8'h0, 4);
    bus(1'b1, `CPM_ADDR_CTRL, 32'h1);
    sw(1'b0, 1'b1, 8'h0, 3);
    status(`CPM_CODE_INIT, 3'b001);
    sw(1'b1, 1'b1, 8'h0, 8);
    status(`CPM_CODE_ENABLED, 3'b101);
  endtask
  task stop_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    resetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    pos = 1'b0;
    nc_first = 1'b1;
    skew = 8'h0;
    fail_count = 0;
    n_compared = 0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_enable_drop();
    t_err(1'b1, `CPM_CODE_WAIT_NO, `CPM_CODE_ERR1);
    t_err(1'b0, `CPM_CODE_WAIT_NC, `CPM_CODE_ERR2);
    t_err3();
    stop_test();
  end
endmodule
